// File: core/epwm_map.vh
`ifndef EPWM_MAP_VH
`define EPWM_MAP_VH
// ==========================================
// Clock and resolution.
`define CLK_PERIOD_PS 5000
`define NATIVE_RES_PS 10400
`define DITHER_RES_PS 1300
`define DITHER_BITS 3
`define NUM_ENG 6
// ==========================================
// Address slots: haddr[8:6] selects an engine or the global slot.
`define GLB_SLOT 3'h6
// Word indices inside an engine slot (byte offset is four times).
`define W_CTRL 4'h0
`define W_TIME0 4'h1
`define W_TIME3 4'h4
`define W_CFG0 4'h5
`define W_CFG3 4'h8
`define W_STAT 4'h9
`define W_MSEL 4'ha
// Word indices inside the global slot.
`define G_PAIR2 4'h2
`define G_IRQ_STAT 4'h3
`define G_IRQ_MASK 4'h4
// ==========================================
// Control word fields.
`define CTRL_EN 0
`define CTRL_DITH 1
`define CTRL_FRAC 2
`define CTRL_SOFT 8
`define CTRL_RESUME 9
// Per-state configuration fields.
`define CFG_EV 0
`define CFG_TMR_EN 3
`define CFG_EV_NXT 4
`define CFG_TM_NXT 6
`define CFG_EV_LVL 8
`define CFG_TM_LVL 9
`define CFG_EV_HOLD 10
`define CFG_IRQ_EN 11
`define CFG_ASYNC 12
// Pair coupling fields and modes.
`define PAIR_DRV 3
`define CPL_SINGLE 3'h0
`define CPL_SYNC 3'h1
`define CPL_ASYNC 3'h2
`define CPL_SYNC2 3'h3
`define CPL_ASYNC2 3'h4
`define CPL_EXT 3'h5
// Engine state codes; run states have bit 2 set.
`define ST_IDLE 3'h0
`define ST_HOLD 3'h1
`define ST_RUN0 3'h4
// Reset values.
`define RST_WORD 32'h00000000
`endif

// File: core/event_pwm_engine.v
`timescale 1ns/100ps
`include "epwm_map.vh"
module event_pwm_engine (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Configuration from the register file.
  input wire enable,
  input wire resume,
  input wire dither_en,
  input wire [2:0] dither_frac,
  input wire [63:0] time_flat,
  input wire [59:0] cfg_flat,
  // Event inputs from the matrix, already in the hclk domain.
  input wire [2:0] ev_in,
  // State and pulses.
  output reg pwm_r,
  output reg [2:0] state_r,
  output reg trans_r,
  output reg hold_r,
  output reg idle_r
);
  reg [2:0] ev_prev_r;
  reg [15:0] cnt_r;
  reg [2:0] acc_r;
  reg [2:0] state_nxt;
  reg pwm_nxt;
  wire run = state_r[2];
  wire [1:0] ri = state_r[1:0];
  wire [14:0] cfg = cfg_flat[ri*15 +: 15];
  wire [15:0] tval = time_flat[ri*16 +: 16];
  // ==========================================
  // Timer with fractional dither.
  // The accumulator carry stretches one period by a cycle, so the
  // average edge moves in eighths of a clock period.
  wire [3:0] acc_sum = {1'b0, acc_r} + {1'b0, dither_frac};
  wire ext = dither_en & acc_sum[3];
  wire [16:0] tlim = {1'b0, tval} + {16'h0000, ext};
  wire hit = run & cfg[`CFG_TMR_EN] & ({1'b0, cnt_r} >= tlim);
  // ==========================================
  // Event qualification: edge for synchronous, level for asynchronous.
  wire [2:0] rise = ev_in & ~ev_prev_r;
  wire [2:0] lvl_sel = cfg[`CFG_ASYNC +: 3];
  wire [2:0] act = (lvl_sel & ev_in) | (~lvl_sel & rise);
  wire ev_hit = run & (|(cfg[`CFG_EV +: 3] & act));
  wire take = ev_hit | hit;

  // Next state; an event outranks the timer in the same cycle.
  always @* begin
    state_nxt = state_r;
    pwm_nxt = pwm_r;
    if (!enable) begin
      state_nxt = `ST_IDLE;
      pwm_nxt = 1'b0;
    end else begin
      case (state_r)
        `ST_IDLE: begin
          state_nxt = `ST_RUN0;
        end
        `ST_HOLD: begin
          if (resume) begin
            state_nxt = `ST_RUN0;
          end
        end
        default: begin
          if (!run) begin
            state_nxt = `ST_IDLE;
          end else if (ev_hit) begin
            state_nxt = cfg[`CFG_EV_HOLD] ? `ST_HOLD : {1'b1, cfg[`CFG_EV_NXT +: 2]};
            pwm_nxt = cfg[`CFG_EV_LVL];
          end else if (hit) begin
            state_nxt = {1'b1, cfg[`CFG_TM_NXT +: 2]};
            pwm_nxt = cfg[`CFG_TM_LVL];
          end
        end
      endcase
    end
  end

  // State, counter and pulse registers.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= `ST_IDLE;
      pwm_r <= 1'b0;
      ev_prev_r <= 3'h0;
      cnt_r <= 16'h0000;
      acc_r <= 3'h0;
      trans_r <= 1'b0;
      hold_r <= 1'b0;
      idle_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pwm_r <= pwm_nxt;
      ev_prev_r <= ev_in;
      if ((state_nxt != state_r) || take) begin
        cnt_r <= 16'h0000;
      end else if (run) begin
        cnt_r <= cnt_r + 16'h0001;
      end
      if (hit && !ev_hit && dither_en) begin
        acc_r <= acc_sum[2:0];
      end
      trans_r <= (take & cfg[`CFG_IRQ_EN] & enable) | (!run && (state_nxt != state_r));
      hold_r <= (state_nxt == `ST_HOLD) && (state_r != `ST_HOLD);
      idle_r <= (state_nxt == `ST_IDLE) && (state_r != `ST_IDLE);
    end
  end
endmodule

// File: core/event_pwm_matrix.v
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "epwm_map.vh"
// Operation
// - Six independent engines, each alone or grouped in pairs.
// - Each engine has idle, four run states and a hold state.
// - Four 16-bit time registers per engine, one per run state.
// - Transitions come from synchronous events, asynchronous events or the timer.
// - Any transition may raise an interrupt request.
// - Eight interrupt request lines leave the subsystem.
// - Edges land on whole clock periods without dithering.
// - Dithering gives one eighth of a clock period on average.
// - Six coupling modes; pair pulses on own outputs or merged.
// - Coupling picked by global and drive-out fields of a pair register.
// - Configured engines run on events with no software action.
// - Three event inputs per engine, each with its own two-bit select.
// - Only outputs of engines 0, 1 and 5 feed back into the matrix.
// - Engine 0 source table for its three inputs.
// - Engine 1 source table for its three inputs.
// - Engine 2 source table, input 1 code 11 is engine 0 output.
// - Engine 3 source table, input 1 code 11 is engine 1 output.
// - Engine 4 source table, input 1 code 11 is engine 5 output.
// - Engine 5 source table for its three inputs.
// - A transition may set the output level per its configuration.
module event_pwm_matrix (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave.
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  // Event sources.
  input wire [3:0] comparator_output,
  input wire [5:0] fast_digital_input,
  // Outputs.
  output reg [5:0] pwm_out,
  output reg [7:0] irq
);
  integer i;
  genvar n, y, p, k;

  // ==========================================
  // Register storage.
  reg [4:0] ctrl_r [0:5];
  reg [15:0] time_r [0:23];
  reg [14:0] cfg_r [0:23];
  reg [5:0] msel_r [0:5];
  reg [3:0] pair_r [0:2];
  reg [7:0] irq_stat_r;
  reg [7:0] irq_mask_r;
  reg [5:0] soft_evt_r;
  reg [5:0] resume_r;
  reg wr_r;
  reg [6:0] waddr_r;
  reg [31:0] rd_nxt;

  // Engine side wires.
  wire [5:0] eng_pwm;
  wire [17:0] eng_state;
  wire [5:0] eng_trans;
  wire [5:0] eng_hold;
  wire [5:0] eng_idle;
  wire [17:0] ev;
  wire [5:0] en_eff;
  wire [5:0] res_eff;
  wire [5:0] pwm_nxt;
  wire [71:0] cand;
  wire [383:0] time_flat;
  wire [359:0] cfg_flat;

  // ==========================================
  // Helper functions.
  // Picks one of four matrix candidates by a two-bit code.
  function pick;
    input [3:0] c;
    input [1:0] s;
    begin
      pick = c[s];
    end
  endfunction

  // Coupling modes whose odd engine starts with the even one.
  function is_sync;
    input [2:0] m;
    begin
      is_sync = (m == `CPL_SYNC) || (m == `CPL_SYNC2);
    end
  endfunction

  // Coupling modes in which the engines release each other from hold.
  function is_two;
    input [2:0] m;
    begin
      is_two = (m == `CPL_SYNC2) || (m == `CPL_ASYNC2);
    end
  endfunction

  // ==========================================
  // Input synchronisers.
  // Comparators and pins are unrelated to hclk, so each bit passes two
  // flip-flops; only sync_r is used further on.
  reg [9:0] meta_r;
  reg [9:0] sync_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= 10'h000;
      sync_r <= 10'h000;
    end else begin
      meta_r <= {fast_digital_input, comparator_output};
      sync_r <= meta_r;
    end
  end
  wire [3:0] acmp = sync_r[3:0];
  wire [5:0] dg = sync_r[9:4];

  // ==========================================
  // Connection matrix, each nibble ordered {code 11, 10, 01, 00}.
  assign cand[3:0] = {dg[5], dg[2], dg[0], acmp[0]};
  assign cand[7:4] = {acmp[3], dg[3], dg[0], acmp[1]};
  assign cand[11:8] = {soft_evt_r[0], dg[4], dg[1], acmp[2]};
  assign cand[15:12] = {dg[0], dg[3], dg[1], acmp[1]};
  assign cand[19:16] = {acmp[3], dg[4], dg[1], acmp[2]};
  assign cand[23:20] = {soft_evt_r[1], dg[5], dg[2], acmp[0]};
  assign cand[27:24] = {dg[1], dg[4], dg[2], acmp[2]};
  assign cand[31:28] = {eng_pwm[0], dg[5], dg[2], acmp[0]};
  assign cand[35:32] = {soft_evt_r[2], dg[0], dg[3], acmp[1]};
  assign cand[39:36] = {dg[2], dg[5], dg[3], acmp[0]};
  assign cand[43:40] = {eng_pwm[1], dg[0], dg[3], acmp[1]};
  assign cand[47:44] = {soft_evt_r[3], dg[1], dg[4], acmp[2]};
  assign cand[51:48] = {dg[3], dg[0], dg[4], acmp[1]};
  assign cand[55:52] = {eng_pwm[5], dg[1], dg[4], acmp[2]};
  assign cand[59:56] = {soft_evt_r[4], dg[2], dg[5], acmp[0]};
  assign cand[63:60] = {dg[4], dg[1], dg[5], acmp[2]};
  assign cand[67:64] = {acmp[3], dg[2], dg[5], acmp[0]};
  assign cand[71:68] = {soft_evt_r[5], dg[3], dg[0], acmp[1]};

  // Each input has its own select field, so the three never interact.
  generate
    for (n = 0; n < `NUM_ENG; n = n + 1) begin : g_sel
      for (y = 0; y < 3; y = y + 1) begin : g_in
        assign ev[n*3+y] = pick(cand[(n*3+y)*4 +: 4], msel_r[n][y*2 +: 2]);
      end
    end
  endgenerate

  // ==========================================
  // Pair coupling.
  // External control hands both enables to the even engine's input 2,
  // so a pin can start and stop the pair without software.
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_pair
      wire [2:0] mode = pair_r[p][2:0];
      wire drv = pair_r[p][`PAIR_DRV];
      wire ext_ctl = (mode == `CPL_EXT);
      assign en_eff[2*p] = ext_ctl ? ev[6*p+2] : ctrl_r[2*p][`CTRL_EN];
      assign en_eff[2*p+1] = ext_ctl ? ev[6*p+2] :
        (is_sync(mode) ? ctrl_r[2*p][`CTRL_EN] : ctrl_r[2*p+1][`CTRL_EN]);
      assign res_eff[2*p] = resume_r[2*p] | (is_two(mode) & eng_hold[2*p+1]);
      assign res_eff[2*p+1] = resume_r[2*p+1] | (is_two(mode) & eng_hold[2*p]);
      // Merged drive puts both pulse trains on each output of the pair.
      assign pwm_nxt[2*p] = drv ? (eng_pwm[2*p] | eng_pwm[2*p+1]) : eng_pwm[2*p];
      assign pwm_nxt[2*p+1] = drv ? (eng_pwm[2*p] | eng_pwm[2*p+1]) : eng_pwm[2*p+1];
    end
  endgenerate

  // ==========================================
  // Engines.
  generate
    for (n = 0; n < `NUM_ENG; n = n + 1) begin : g_eng
      for (k = 0; k < 4; k = k + 1) begin : g_flat
        assign time_flat[n*64+k*16 +: 16] = time_r[n*4+k];
        assign cfg_flat[n*60+k*15 +: 15] = cfg_r[n*4+k];
      end
      event_pwm_engine u_eng (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(en_eff[n]),
        .resume(res_eff[n]),
        .dither_en(ctrl_r[n][`CTRL_DITH]),
        .dither_frac(ctrl_r[n][`CTRL_FRAC +: 3]),
        .time_flat(time_flat[n*64 +: 64]),
        .cfg_flat(cfg_flat[n*60 +: 60]),
        .ev_in(ev[n*3 +: 3]),
        .pwm_r(eng_pwm[n]),
        .state_r(eng_state[n*3 +: 3]),
        .trans_r(eng_trans[n]),
        .hold_r(eng_hold[n]),
        .idle_r(eng_idle[n])
      );
    end
  endgenerate

  // ==========================================
  // Bus address phase and read data.
  // Read data are latched at the address phase, so a read right behind
  // a write to the same word returns the value before that write.
  wire take = hsel & htrans[1] & hready;
  wire [2:0] re = haddr[8:6];
  wire [3:0] rw = haddr[5:2];
  wire [3:0] rt = rw - `W_TIME0;
  wire [3:0] rc = rw - `W_CFG0;
  wire [4:0] rti = {re[2:0], 2'b00} + {3'b000, rt[1:0]};
  wire [4:0] rci = {re[2:0], 2'b00} + {3'b000, rc[1:0]};
  wire rmap = (haddr[31:9] == 23'h000000);

  // Combinational read multiplexer; unmapped words read zero.
  always @* begin
    rd_nxt = `RST_WORD;
    if (rmap && (re < `GLB_SLOT)) begin
      if (rw == `W_CTRL) begin
        rd_nxt = {22'h000000, 5'h00, ctrl_r[re]};
      end else if ((rw >= `W_TIME0) && (rw <= `W_TIME3)) begin
        rd_nxt = {16'h0000, time_r[rti]};
      end else if ((rw >= `W_CFG0) && (rw <= `W_CFG3)) begin
        rd_nxt = {17'h00000, cfg_r[rci]};
      end else if (rw == `W_STAT) begin
        rd_nxt = {28'h0000000, eng_pwm[re], eng_state[re*3 +: 3]};
      end else if (rw == `W_MSEL) begin
        rd_nxt = {26'h0000000, msel_r[re]};
      end
    end else if (rmap && (re == `GLB_SLOT)) begin
      if (rw <= `G_PAIR2) begin
        rd_nxt = {28'h0000000, pair_r[rw[1:0]]};
      end else if (rw == `G_IRQ_STAT) begin
        rd_nxt = {24'h000000, irq_stat_r};
      end else if (rw == `G_IRQ_MASK) begin
        rd_nxt = {24'h000000, irq_mask_r};
      end
    end
  end

  // Zero wait state slave; the answer is always OKAY.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      waddr_r <= 7'h00;
      hrdata <= `RST_WORD;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_r <= take & hwrite & rmap;
      waddr_r <= haddr[8:2];
      hrdata <= (take && !hwrite) ? rd_nxt : `RST_WORD;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ==========================================
  // Data phase writes.
  wire [2:0] we = waddr_r[6:4];
  wire [3:0] ww = waddr_r[3:0];
  wire [3:0] wt = ww - `W_TIME0;
  wire [3:0] wc = ww - `W_CFG0;
  wire [4:0] wti = {we[2:0], 2'b00} + {3'b000, wt[1:0]};
  wire [4:0] wci = {we[2:0], 2'b00} + {3'b000, wc[1:0]};
  wire weng = wr_r && (we < `GLB_SLOT);
  wire wglb = wr_r && (we == `GLB_SLOT);
  wire [7:0] irq_clr = (wglb && (ww == `G_IRQ_STAT)) ? hwdata[7:0] : 8'h00;
  wire [7:0] irq_set = {|eng_idle, |eng_hold, eng_trans};

  // Configuration registers and the one-cycle software strobes.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < 24; i = i + 1) begin
        time_r[i] <= 16'h0000;
        cfg_r[i] <= 15'h0000;
      end
      for (i = 0; i < 6; i = i + 1) begin
        ctrl_r[i] <= 5'h00;
        msel_r[i] <= 6'h00;
      end
      for (i = 0; i < 3; i = i + 1) begin
        pair_r[i] <= 4'h0;
      end
      irq_mask_r <= 8'h00;
      soft_evt_r <= 6'h00;
      resume_r <= 6'h00;
    end else begin
      soft_evt_r <= 6'h00;
      resume_r <= 6'h00;
      if (weng && (ww == `W_CTRL)) begin
        ctrl_r[we] <= hwdata[4:0];
        soft_evt_r[we] <= hwdata[`CTRL_SOFT];
        resume_r[we] <= hwdata[`CTRL_RESUME];
      end
      if (weng && (ww >= `W_TIME0) && (ww <= `W_TIME3)) begin
        time_r[wti] <= hwdata[15:0];
      end
      if (weng && (ww >= `W_CFG0) && (ww <= `W_CFG3)) begin
        cfg_r[wci] <= hwdata[14:0];
      end
      if (weng && (ww == `W_MSEL)) begin
        msel_r[we] <= hwdata[5:0];
      end
      if (wglb && (ww <= `G_PAIR2)) begin
        pair_r[ww[1:0]] <= hwdata[3:0];
      end
      if (wglb && (ww == `G_IRQ_MASK)) begin
        irq_mask_r <= hwdata[7:0];
      end
    end
  end

  // ==========================================
  // Interrupt lines and outputs.
  // A new event in the clearing cycle survives, because set is applied
  // after the write-one-to-clear mask.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= 8'h00;
      irq <= 8'h00;
      pwm_out <= 6'h00;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      irq <= ((irq_stat_r & ~irq_clr) | irq_set) & irq_mask_r;
      pwm_out <= pwm_nxt;
    end
  end
endmodule

// File: testbench/event_pwm_matrix_assertions.sv
`timescale 1ns/100ps
// ==========================================
// Port checks on the register bus and the engine outputs.
module event_pwm_matrix_assertions (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Bus request side.
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  // Bus answer side.
  input wire hreadyout,
  input wire [31:0] hrdata,
  input wire hresp,
  // Outputs.
  input wire [5:0] pwm_out,
  input wire [7:0] irq
);
  wire rd_now = hsel & htrans[1] & hready & ~hwrite;
  wire wr_now = hsel & htrans[1] & hready & hwrite;
  wire irq_wr = wr_now && (haddr == 32'h18c || haddr == 32'h190);
  wire time_hit = haddr[31:9] == 23'h0 && haddr[8:6] < 3'h6 && haddr[5:2] >= 4'h1
    && haddr[5:2] <= 4'h4 && haddr[1:0] == 2'h0;
  reg wp_r;
  reg cv_r;
  reg [31:0] wa_r;
  reg [31:0] ca_r;
  reg [15:0] cd_r;
  reg [3:0] hist_r;
  // Remember the last finished write, so later time word reads can be judged.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_r <= 1'b0;
      cv_r <= 1'b0;
      wa_r <= 32'h0;
      ca_r <= 32'h0;
      cd_r <= 16'h0;
      hist_r <= 4'h0;
    end else begin
      wp_r <= wr_now;
      wa_r <= haddr;
      hist_r <= {hist_r[2:0], irq_wr};
      if (wp_r) begin
        ca_r <= wa_r;
        cd_r <= hwdata[15:0];
        cv_r <= 1'b1;
      end
    end
  end
  sequence s_rd;
    rd_now;
  endsequence
  sequence s_time_rd;
    rd_now && time_hit && cv_r && haddr == ca_r;
  endsequence
  chk_ready_high: assert property (@(posedge hclk) disable iff (!hresetn) hreadyout == 1'b1)
    else $error("hreadyout low");
  chk_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn) hresp == 1'b0)
    else $error("hresp not okay");
  chk_rdata_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    !rd_now |=> hrdata == 32'h0) else $error("hrdata outside read");
  chk_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    s_rd ##0 haddr[31:9] != 23'h0 |=> hrdata == 32'h0) else $error("unmapped read");
  chk_time_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    s_time_rd |=> hrdata == {16'h0, $past(cd_r)}) else $error("time word mismatch");
  chk_status_code: assert property (@(posedge hclk) disable iff (!hresetn)
    s_rd ##0 (haddr[31:9] == 23'h0 && haddr[8:6] < 3'h6 && haddr[5:2] == 4'h9)
    |=> hrdata[31:4] == 28'h0 && hrdata[2:1] != 2'b01) else $error("bad state code");
  chk_reset_outputs: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> pwm_out == 6'h0 && irq == 8'h0) else $error("outputs after reset");
  chk_irq_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (hist_r == 4'h0 && !irq_wr) |=> (irq & $past(irq)) == $past(irq))
    else $error("irq dropped alone");
endmodule

// File: testbench/event_source_model.sv
`timescale 1ns/100ps
// ==========================================
// Event sources and power stage load.
module event_source_model (
  // Clock.
  input wire hclk,
  // Engine outputs seen by the power stage.
  input wire [5:0] pwm_out,
  // Event sources toward the device.
  output reg [3:0] comparator_output,
  output reg [5:0] fast_digital_input
);
  reg last_r;
  integer cnt;
  integer high_len;
  integer low_len;
  // Quiet lines at time zero; the comparators hold a steady level.
  initial begin
    comparator_output = 4'h0;
    fast_digital_input = 6'h0;
    last_r = 1'b0;
    cnt = 0;
    high_len = 0;
    low_len = 0;
  end
  // Four cycles high, so the pulse survives the two-flop synchroniser.
  task pulse_dig(input integer n);
    begin
      @(posedge hclk);
      fast_digital_input[n] <= 1'b1;
      repeat (4) @(posedge hclk);
      fast_digital_input[n] <= 1'b0;
    end
  endtask
  // Comparator level change; the level then stays until the next call.
  task set_cmp(input integer n, input v);
    begin
      @(posedge hclk);
      comparator_output[n] <= v;
    end
  endtask
  // Run lengths of engine 0 output, as the load sees them.
  always @(posedge hclk) begin
    if (pwm_out[0] === last_r) begin
      cnt <= cnt + 1;
    end else begin
      if (last_r) high_len <= cnt;
      else low_len <= cnt;
      cnt <= 1;
    end
    last_r <= pwm_out[0];
  end
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/100ps
// ==========================================
// Register-driven tests of the engine matrix.
module tb_top;
  reg hclk;
  reg hresetn;
  reg hsel;
  reg hwrite;
  reg [1:0] htrans;
  reg [31:0] haddr;
  reg [31:0] hwdata;
  reg [31:0] rdat;
  wire hreadyout;
  wire hresp;
  wire [31:0] hrdata;
  wire [3:0] comparator_output;
  wire [5:0] fast_digital_input;
  wire [5:0] pwm_out;
  wire [7:0] irq;
  integer error_cnt;
  integer samples_checked;
  integer n;
  event_pwm_matrix u_event_pwm_matrix (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .comparator_output(comparator_output), .fast_digital_input(fast_digital_input),
    .pwm_out(pwm_out), .irq(irq));
  event_source_model u_event_source_model (.hclk(hclk), .pwm_out(pwm_out),
    .comparator_output(comparator_output), .fast_digital_input(fast_digital_input));
  // Clock at 200 MHz.
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Compare and count; a mismatch is reported at once.
  task cmp32(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // One single transfer; the master waits for hready in each phase.
  task ahb(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rdat = hrdata;
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task rd_cmp(input [31:0] a, input [31:0] exp);
    begin
      ahb(1'b0, a, 32'h0);
      cmp32(rdat, exp);
    end
  endtask
  // Verdict and end of run.
  task results;
    begin
      $display("checks=%0d errors=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // Watchdog; the tests need a few hundred cycles at most.
  initial begin
    #50000;
    error_cnt = error_cnt + 1;
    results;
  end
  // Main sequence.
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd_cmp(32'h24, 32'h0);
    wr(32'h400, 32'hffff);
    rd_cmp(32'h400, 32'h0);
    wr(32'h84, 32'hffffffff);
    rd_cmp(32'h84, 32'hffff);
    $display("test regs done");
    // Input 0 select 01 takes digital line n on every engine.
    for (n = 0; n < 6; n = n + 1) begin
      wr(n * 64 + 32'h28, 32'h1);
      wr(n * 64 + 32'h14, 32'h111);
      wr(n * 64, 32'h1);
      repeat (4) @(posedge hclk);
      rd_cmp(n * 64 + 32'h24, 32'h4);
      u_event_source_model.pulse_dig(n);
      repeat (8) @(posedge hclk);
      rd_cmp(n * 64 + 32'h24, 32'hd);
      cmp32({31'h0, pwm_out[n]}, 32'h1);
    end
    $display("test matrix done");
    // Leaving idle is flagged per engine; the mask gates the lines.
    rd_cmp(32'h18c, 32'h3f);
    cmp32({24'h0, irq}, 32'h0);
    wr(32'h190, 32'hff);
    repeat (3) @(posedge hclk);
    cmp32({24'h0, irq}, 32'h3f);
    wr(32'h18c, 32'h3f);
    rd_cmp(32'h18c, 32'h0);
    wr(32'h0, 32'h0);
    repeat (3) @(posedge hclk);
    rd_cmp(32'h24, 32'h0);
    cmp32({24'h0, irq}, 32'h80);
    $display("test irq done");
    // Timer waveform on engine 0; its rise feeds engine 2 input 1.
    wr(32'h4, 32'h7);
    wr(32'h8, 32'h7);
    wr(32'h14, 32'h248);
    wr(32'h18, 32'h8);
    wr(32'ha8, 32'hd);
    wr(32'h98, 32'h22);
    wr(32'h0, 32'h1);
    repeat (60) @(posedge hclk);
    cmp32(u_event_source_model.high_len, 32'h8);
    cmp32(u_event_source_model.low_len, 32'h8);
    rd_cmp(32'h4, 32'h7);
    rd_cmp(32'ha4, 32'h6);
    $display("test timer done");
    // A half period of dither lengthens every second timer state by one clock.
    wr(32'h0, 32'h13);
    repeat (60) @(posedge hclk);
    cmp32(u_event_source_model.high_len + u_event_source_model.low_len, 32'h11);
    // Merged drive on pair 2/3 puts the one high engine output on both pins.
    wr(32'h184, 32'h8);
    repeat (2) @(posedge hclk);
    cmp32({30'h0, pwm_out[3:2]}, 32'h3);
    wr(32'h184, 32'h0);
    repeat (2) @(posedge hclk);
    cmp32({30'h0, pwm_out[3:2]}, 32'h2);
    $display("test dither done");
    // A software event sends engine 1 to hold; a resume strobe brings it back.
    wr(32'h58, 32'h404);
    wr(32'h68, 32'h31);
    wr(32'h40, 32'h101);
    rd_cmp(32'h64, 32'h1);
    wr(32'h40, 32'h201);
    rd_cmp(32'h64, 32'h4);
    rd_cmp(32'h18c, 32'hc3);
    $display("test hold done");
    // Every coupling mode with merged drive on pair 4/5.
    for (n = 0; n < 6; n = n + 1) begin
      wr(32'h188, n + 8);
      rd_cmp(32'h188, n + 8);
    end
    // External control: comparator 0 on engine 4 input 2 gates pair 4/5.
    rd_cmp(32'h164, 32'h0);
    u_event_source_model.set_cmp(0, 1'b1);
    repeat (4) @(posedge hclk);
    rd_cmp(32'h164, 32'h4);
    $display("test coupling done");
    results;
  end
endmodule
bind event_pwm_matrix event_pwm_matrix_assertions u_event_pwm_matrix_assertions (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .pwm_out(pwm_out), .irq(irq));
